//--- gpd_pkg.sv
// Package for the 8-bit general-purpose port: register map, field layout and carriers
package gpd_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [3:0] GPD_OFS_PIN_LEVELS = 4'h0;
  localparam logic [3:0] GPD_OFS_OUT_LATCH  = 4'h4;
  localparam logic [3:0] GPD_OFS_DIRECTION  = 4'h8;
  localparam logic [3:0] GPD_OFS_PIN_SELECT = 4'hC;

  // Register decode indices
  localparam logic [2:0] GPD_IDX_PIN_LEVELS = 3'h0;
  localparam logic [2:0] GPD_IDX_OUT_LATCH  = 3'h1;
  localparam logic [2:0] GPD_IDX_DIRECTION  = 3'h2;
  localparam logic [2:0] GPD_IDX_PIN_SELECT = 3'h3;
  localparam logic [2:0] GPD_IDX_UNMAPPED   = 3'h4;

  // Reset values
  localparam logic [7:0] GPD_LATCH_RESET  = 8'h00;
  localparam logic [7:0] GPD_DIR_RESET    = 8'hFF;
  localparam logic [7:0] GPD_SELECT_RESET = 8'h00;

  // Pin select register fields; a 1 puts the function on this port, except bits 1 and 4, which only act when both are set
  localparam int GPD_SEL_SERIAL   = 0;
  localparam int GPD_SEL_PWM_COMP = 1;
  localparam int GPD_SEL_FAULT_A  = 2;
  localparam int GPD_SEL_TIMER    = 3;
  localparam int GPD_SEL_PWM_CH3_PRIMARY_OUT_EN  = 4;
  localparam int GPD_SEL_PWM_CH4_PRIMARY_OUT_EN  = 5;
  localparam int GPD_SEL_PWM_CH4_COMPLEMENT_OUT_EN  = 6;
  localparam logic [7:0] GPD_SELECT_MASK = 8'h7F;

  // Pin positions of the muxed functions
  localparam int GPD_PIN_TIMER  = 0;
  localparam int GPD_PIN_SDO    = 1;
  localparam int GPD_PIN_SDA    = 2;
  localparam int GPD_PIN_SCK    = 3;
  localparam int GPD_PIN_FAULT  = 4;
  localparam int GPD_PIN_PWM_C3 = 5;
  localparam int GPD_PIN_PWM_P4 = 6;
  localparam int GPD_PIN_PWM_C4 = 7;

  // AXI responses
  localparam logic [1:0] GPD_RESP_OKAY   = 2'b00;
  localparam logic [1:0] GPD_RESP_SLVERR = 2'b10;

  // Synchronous serial peripheral drive toward the pins
  typedef struct packed {
    logic active;
    logic sdo;
    logic sda_out;
    logic sck_out;
  } gpd_serial_t;

  // PWM channel outputs toward the pins
  typedef struct packed {
    logic pwm_ch3_primary_out;
    logic pwm_ch4_primary_out;
    logic pwm_ch4_complement_out;
  } gpd_pwm_t;

  // Levels on the alternate pins of other ports
  typedef struct packed {
    logic fault_a;
    logic timer_clk;
    logic sdi;
    logic sck;
  } gpd_alt_t;

  // Inputs handed on to the peripherals
  typedef struct packed {
    logic fault_input_a;
    logic timer0_ext_clock_in;
    logic timer5_ext_clock_in;
    logic sdi;
    logic sck_in;
  } gpd_route_t;

  // Whole state of the port block
  typedef struct packed {
    logic [7:0] port_output_latch;
    logic [7:0] port_direction;
    logic [7:0] pin_select;
    logic [7:0] pin_sample;
    logic       aw_held;
    logic [3:0] aw_addr;
    logic       w_held;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } gpd_state_t;

endpackage

//--- gpd_port.sv
// Eight-pin general-purpose port with peripheral pin muxing and an AXI4-Lite register slave
`timescale 1ns/1ps

module gpd_port
  import gpd_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int PINS   = 8
)
(
  // Clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,

  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,

  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,

  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,

  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,

  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,

  // Port pins
  input  wire logic [PINS-1:0]   pin_in,
  output logic [PINS-1:0]        pin_out,
  output logic [PINS-1:0]        pin_oe_n,

  // Peripherals driving the pins
  input  wire gpd_serial_t       serial_drive,
  input  wire gpd_pwm_t          pwm_drive,

  // Alternate pins on other ports
  input  wire gpd_alt_t          alt_pins,

  // Inputs passed on to the peripherals
  output gpd_route_t             route_out,
  output logic [7:0]             pin_select_out
);

  gpd_state_t state_reg;
  gpd_state_t state_next;

  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       wr_commit;
  logic [2:0] wr_index;
  logic [2:0] rd_index;
  logic [7:0] rd_value;
  logic [7:0] wr_value;

  // Register decode, shared by the read and write paths
  function automatic logic [2:0] gpd_decode(input logic [3:0] addr);
    logic [2:0] idx;
    idx = GPD_IDX_UNMAPPED;
    unique case (addr)
      GPD_OFS_PIN_LEVELS: idx = GPD_IDX_PIN_LEVELS;
      GPD_OFS_OUT_LATCH:  idx = GPD_IDX_OUT_LATCH;
      GPD_OFS_DIRECTION:  idx = GPD_IDX_DIRECTION;
      GPD_OFS_PIN_SELECT: idx = GPD_IDX_PIN_SELECT;
      default:            idx = GPD_IDX_UNMAPPED;
    endcase
    return idx;
  endfunction

  // Handshakes; the slave stalls new requests while a response is pending
  assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready  = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;

  assign aw_take   = clk_en && s_axi_awvalid && s_axi_awready;
  assign w_take    = clk_en && s_axi_wvalid && s_axi_wready;
  assign ar_take   = clk_en && s_axi_arvalid && s_axi_arready;
  assign wr_commit = state_reg.aw_held && state_reg.w_held;

  assign wr_index = gpd_decode(state_reg.aw_addr);
  assign rd_index = gpd_decode(s_axi_araddr[3:0]);

  // Only byte lane 0 holds data; a write without it leaves the register alone
  assign wr_value = state_reg.w_data;

  always_comb
  begin
    unique case (rd_index)
      GPD_IDX_PIN_LEVELS: rd_value = state_reg.pin_sample;
      GPD_IDX_OUT_LATCH:  rd_value = state_reg.port_output_latch;
      GPD_IDX_DIRECTION:  rd_value = state_reg.port_direction;
      GPD_IDX_PIN_SELECT: rd_value = state_reg.pin_select;
      default:            rd_value = 8'h00;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;

    // Pins are taken as synchronous, one sample per cycle
    state_next.pin_sample = pin_in;

    // Write address and data arrive in either order
    if (aw_take)
    begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr[3:0];
    end
    if (w_take)
    begin
      state_next.w_held  = 1'b1;
      state_next.w_data  = s_axi_wdata[7:0];
      state_next.w_lane0 = s_axi_wstrb[0];
    end

    // Commit once both halves are held, then answer
    if (wr_commit)
    begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = GPD_RESP_OKAY;
      unique case (wr_index)
        GPD_IDX_PIN_LEVELS,
        GPD_IDX_OUT_LATCH:
        begin
          if (state_reg.w_lane0)
          begin
            state_next.port_output_latch = wr_value;
          end
        end
        GPD_IDX_DIRECTION:
        begin
          if (state_reg.w_lane0)
          begin
            state_next.port_direction = wr_value;
          end
        end
        GPD_IDX_PIN_SELECT:
        begin
          if (state_reg.w_lane0)
          begin
            state_next.pin_select = wr_value & GPD_SELECT_MASK;
          end
        end
        default:
        begin
          state_next.bresp = GPD_RESP_SLVERR;
        end
      endcase
    end
    else if (state_reg.bvalid && s_axi_bready && clk_en)
    begin
      state_next.bvalid = 1'b0;
    end

    // Read answer is registered, so the value is held while rready is low
    if (ar_take)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_value;
      state_next.rresp  = (rd_index == GPD_IDX_UNMAPPED) ? GPD_RESP_SLVERR : GPD_RESP_OKAY;
    end
    else if (state_reg.rvalid && s_axi_rready)
    begin
      state_next.rvalid = 1'b0;
    end
  end

  // All state freezes while the clock enable is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg                   <= '0;
      state_reg.port_output_latch <= GPD_LATCH_RESET;
      state_reg.port_direction    <= GPD_DIR_RESET;
      state_reg.pin_select        <= GPD_SELECT_RESET;
      state_reg.bresp             <= GPD_RESP_OKAY;
      state_reg.rresp             <= GPD_RESP_OKAY;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp  = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rresp  = state_reg.rresp;
  assign s_axi_rdata  = {24'h00_0000, state_reg.rdata};

  // Pin drive; peripheral overrides only matter where the pin is an output
  logic serial_here;
  logic pwm_comp_here;
  logic [PINS-1:0] drive_val;

  assign serial_here   = state_reg.pin_select[GPD_SEL_SERIAL] && serial_drive.active;
  assign pwm_comp_here = state_reg.pin_select[GPD_SEL_PWM_COMP]
                         && state_reg.pin_select[GPD_SEL_PWM_CH3_PRIMARY_OUT_EN];

  always_comb
  begin
    drive_val = state_reg.port_output_latch;
    if (serial_here)
    begin
      drive_val[GPD_PIN_SDO] = serial_drive.sdo;
      drive_val[GPD_PIN_SDA] = serial_drive.sda_out;
      drive_val[GPD_PIN_SCK] = serial_drive.sck_out;
    end
    if (pwm_comp_here)
    begin
      drive_val[GPD_PIN_PWM_C3] = ~pwm_drive.pwm_ch3_primary_out;
    end
    if (state_reg.pin_select[GPD_SEL_PWM_CH4_PRIMARY_OUT_EN])
    begin
      drive_val[GPD_PIN_PWM_P4] = pwm_drive.pwm_ch4_primary_out;
    end
    if (state_reg.pin_select[GPD_SEL_PWM_CH4_COMPLEMENT_OUT_EN])
    begin
      drive_val[GPD_PIN_PWM_C4] = pwm_drive.pwm_ch4_complement_out;
    end
  end

  // Direction 1 releases the driver; direction 0 drives
  assign pin_out  = drive_val;
  assign pin_oe_n = state_reg.port_direction;

  // Input routing toward the peripherals
  logic fault_sel;
  logic timer_sel;

  assign fault_sel = state_reg.pin_select[GPD_SEL_FAULT_A];
  assign timer_sel = state_reg.pin_select[GPD_SEL_TIMER];

  // A fault or timer pin set as output would feed back its own drive, so it reads low instead
  assign route_out.fault_input_a = fault_sel
    ? (state_reg.port_direction[GPD_PIN_FAULT] & state_reg.pin_sample[GPD_PIN_FAULT])
    : alt_pins.fault_a;
  assign route_out.timer0_ext_clock_in = timer_sel
    ? (state_reg.port_direction[GPD_PIN_TIMER] & state_reg.pin_sample[GPD_PIN_TIMER])
    : alt_pins.timer_clk;
  assign route_out.timer5_ext_clock_in = route_out.timer0_ext_clock_in;
  assign route_out.sdi = state_reg.pin_select[GPD_SEL_SERIAL]
    ? state_reg.pin_sample[GPD_PIN_SDA]
    : alt_pins.sdi;
  assign route_out.sck_in = state_reg.pin_select[GPD_SEL_SERIAL]
    ? state_reg.pin_sample[GPD_PIN_SCK]
    : alt_pins.sck;

  // Lets the other ports release the functions this port has taken
  assign pin_select_out = state_reg.pin_select;

endmodule

//--- gpd_board.sv
// Board model facing the eight port pins
`timescale 1ns/1ps
module gpd_board
(
  // Pin drive from the port
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  // Level the board puts on released pins
  input  wire logic [7:0] ext,
  // Wire level seen by the port
  output logic [7:0]      pin_in
);
  // A driven pin reads back its own drive, a released one the board level
  assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
endmodule

//--- gpd_port_asserts.sv
// Concurrent checks on the port block pins and bus handshakes
`timescale 1ns/1ps
module gpd_port_asserts
  import gpd_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Pins and peripherals
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe_n,
  input wire gpd_serial_t serial_drive,
  input wire gpd_pwm_t    pwm_drive,
  input wire gpd_alt_t    alt_pins,
  input wire gpd_route_t  route_out,
  input wire logic [7:0]  pin_select_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_in_two(sig);
    !sig ##1 sig;
  endsequence
  chk_dir_reset: assert property ($rose(aresetn) |-> pin_oe_n == 8'hFF)
    else $error("pins not released after reset");
  chk_write_resp: assert property (wr_taken |=> resp_in_two(s_axi_bvalid))
    else $error("write response late");
  chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  // Pin 0 has no override, so its drive moves only with a committed write
  chk_latch_drive: assert property ($changed(pin_out[0]) |-> $rose(s_axi_bvalid))
    else $error("pin drive moved without a write");
  chk_pwm_ch3_primary_out_inv: assert property (pin_select_out[1] && pin_select_out[4]
    |-> pin_out[5] == !pwm_drive.pwm_ch3_primary_out) else $error("pin 5 not inverted pwm");
  chk_pwm67_pair: assert property (pin_select_out[5] && pin_select_out[6]
    |-> pin_out[7:6] == {pwm_drive.pwm_ch4_complement_out, pwm_drive.pwm_ch4_primary_out})
    else $error("pins 6 and 7 not pwm pair");
  chk_serial_over: assert property (pin_select_out[0] && serial_drive.active
    |-> pin_out[3:1] == {serial_drive.sck_out, serial_drive.sda_out, serial_drive.sdo})
    else $error("serial override missing");
  chk_fault_route: assert property (pin_oe_n[4] |-> route_out.fault_input_a ==
    (pin_select_out[2] ? $past(pin_in[4]) : alt_pins.fault_a)) else $error("fault route");
  chk_timer_route: assert property (pin_oe_n[0] |-> route_out.timer5_ext_clock_in ==
    (pin_select_out[3] ? $past(pin_in[0]) : alt_pins.timer_clk)) else $error("timer route");
endmodule
bind gpd_port gpd_port_asserts chk_i (.*);

//--- testbench.sv
// Self-checking bench for the general-purpose port
`timescale 1ns/1ps
module testbench;
  import gpd_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  pin_in, pin_out, pin_oe_n, pin_select_out, lat, dir, sel;
  logic [7:0]  ext = 8'h00;
  gpd_serial_t serial_drive = '0;
  gpd_pwm_t    pwm_drive = '0;
  gpd_alt_t    alt_pins = '0;
  gpd_route_t  route_out;
  int error_cnt = 0;
  int n_checks = 0;
  always #25 aclk = ~aclk;
  gpd_port dut (.*);
  gpd_board board (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Each bus task waits one edge first so no signal is driven twice in a step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, {24'h00_0000, exp});
  endtask
  function automatic logic [7:0] exp_out(input logic [7:0] l, input logic [7:0] s);
    logic [7:0] o;
    o = l;
    if (s[0] && serial_drive.active)
      o[3:1] = {serial_drive.sck_out, serial_drive.sda_out, serial_drive.sdo};
    if (s[1] && s[4]) o[5] = !pwm_drive.pwm_ch3_primary_out;
    if (s[5]) o[6] = pwm_drive.pwm_ch4_primary_out;
    if (s[6]) o[7] = pwm_drive.pwm_ch4_complement_out;
    return o;
  endfunction
  initial
  begin
    lat = 8'($urandom(32'h9491));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(GPD_OFS_DIRECTION, 8'hFF);
    check(pin_oe_n, 8'hFF);
    rdc(GPD_OFS_OUT_LATCH, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      lat = 8'($urandom);
      sel = 8'($urandom) & GPD_SELECT_MASK;
      dir = (i == 0) ? 8'h00 : (i == 7) ? 8'hFF : 8'($urandom);
      ext <= 8'($urandom);
      serial_drive <= 4'($urandom);
      pwm_drive <= 3'($urandom);
      alt_pins <= 4'($urandom);
      wr(GPD_OFS_OUT_LATCH, 8'h00);
      wr(GPD_OFS_DIRECTION, dir);
      wr(GPD_OFS_OUT_LATCH, lat);
      wr(GPD_OFS_PIN_SELECT, sel);
      rdc(GPD_OFS_OUT_LATCH, lat);
      rdc(GPD_OFS_DIRECTION, dir);
      rdc(GPD_OFS_PIN_SELECT, sel);
      check(pin_oe_n, dir);
      check(pin_out, exp_out(lat, sel));
      rdc(GPD_OFS_PIN_LEVELS, (dir & ext) | (~dir & exp_out(lat, sel)));
      check(route_out.fault_input_a, sel[2] ? dir[4] & ext[4] : alt_pins.fault_a);
      check(route_out.timer0_ext_clock_in, sel[3] ? dir[0] & ext[0] : alt_pins.timer_clk);
      check(route_out.timer5_ext_clock_in, sel[3] ? dir[0] & ext[0] : alt_pins.timer_clk);
      check(route_out.sdi, sel[0] ? ((dir & ext) | (~dir & exp_out(lat, sel))) >> 2 & 1 : alt_pins.sdi);
      check(route_out.sck_in, sel[0] ? ((dir & ext) | (~dir & exp_out(lat, sel))) >> 3 & 1 : alt_pins.sck);
      check(pin_select_out, sel);
      wr(GPD_OFS_PIN_LEVELS, ~lat);
      rdc(GPD_OFS_OUT_LATCH, ~lat);
      check(s_axi_bresp, GPD_RESP_OKAY);
    end
    // Unmapped offsets answer with an error and leave every register alone
    wr(4'h2, 8'hA5);
    check(s_axi_bresp, GPD_RESP_SLVERR);
    rdc(4'h2, 8'h00);
    check(s_axi_rresp, GPD_RESP_SLVERR);
    rdc(GPD_OFS_OUT_LATCH, ~lat);
    print_verdict;
  end
  initial
  begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    print_verdict;
  end
endmodule
